/* File: hw/msl_pkg.sv */
package msl_pkg;
  // ----------------------------------------------------------------
  // timing base
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ         = 64'd125_000_000;
  localparam longint unsigned DEFAULT_BAUD   = 64'd1200;
  localparam longint unsigned HOLD_S         = 64'd5;
  localparam longint unsigned CARRIER_LOSS_S = 64'd30;
  localparam longint unsigned QUIET_MS       = 64'd1000;
  localparam longint unsigned MS_PER_S       = 64'd1000;

  // derived cycle counts (longest times, so they round down)
  localparam int unsigned DEFAULT_DIV = 32'(CLK_HZ / DEFAULT_BAUD);
  localparam int unsigned HOLD_CYC    = 32'(HOLD_S * CLK_HZ);
  localparam int unsigned LOSS_CYC    = 32'(CARRIER_LOSS_S * CLK_HZ);
  localparam int unsigned QUIET_CYC   = 32'(QUIET_MS * CLK_HZ / MS_PER_S);

  // ----------------------------------------------------------------
  // line constants
  // ----------------------------------------------------------------
  localparam logic [5:0] TOGGLE_LIMIT = 6'h32;
  localparam logic [7:0] CR_CHAR      = 8'h0d;
  localparam logic [3:0] CHAR_BITS    = 4'h9;
  localparam int unsigned MODEM_PORT   = 7;
  localparam int unsigned CONSOLE_SLOT = 1;

  localparam logic [1:0] CAUSE_NONE    = 2'h0;
  localparam logic [1:0] CAUSE_DSR     = 2'h1;
  localparam logic [1:0] CAUSE_CARRIER = 2'h2;
  localparam logic [1:0] CAUSE_LOGOFF  = 2'h3;

  typedef enum logic [1:0] {
    SUP_WAIT   = 2'b00,
    SUP_ACTIVE = 2'b01,
    SUP_HOLD   = 2'b10
  } msl_sup_t;

  typedef enum logic [1:0] {
    SNS_ARM  = 2'b00,
    SNS_MEAS = 2'b01,
    SNS_SAMP = 2'b10,
    SNS_LOCK = 2'b11
  } msl_sns_t;
endpackage

/* File: hw/msl_stream_if.sv */
`timescale 1ns/1ps
interface msl_stream_if #(parameter int DATA_W = 8) ();
  logic              valid;
  logic              ready;
  logic [DATA_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: hw/msl_fifo.sv */
`timescale 1ns/1ps
module msl_fifo import msl_pkg::*; #(
  parameter int DATA_W = 8,
  parameter int DEPTH  = 16
) (
  // clock and reset
  input wire logic   ref_clk,
  input wire logic   sys_rst,
  // fill and drain sides
  msl_stream_if.snk  wr,
  msl_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0]     wptr_r, wptr_nxt;
  logic [AW-1:0]     rptr_r, rptr_nxt;
  logic [AW:0]       cnt_r, cnt_nxt;
  logic              in_rdy_r, in_rdy_nxt;
  logic              out_vld_r, out_vld_nxt;
  logic              push, pop;

  // flags are registered so wr.ready and rd.valid come straight from flops
  assign wr.ready = in_rdy_r;
  assign rd.valid = out_vld_r;
  assign rd.data  = mem[rptr_r];

  always_comb begin
    push     = wr.valid & in_rdy_r;
    pop      = rd.ready & out_vld_r;
    wptr_nxt = push ? AW'(wptr_r + 1'b1) : wptr_r;
    rptr_nxt = pop ? AW'(rptr_r + 1'b1) : rptr_r;
    cnt_nxt  = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
    in_rdy_nxt  = cnt_nxt != (AW+1)'(DEPTH);
    out_vld_nxt = cnt_nxt != '0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wptr_r    <= '0;
      rptr_r    <= '0;
      cnt_r     <= '0;
      in_rdy_r  <= 1'b0;
      out_vld_r <= 1'b0;
    end else begin
      wptr_r    <= wptr_nxt;
      rptr_r    <= rptr_nxt;
      cnt_r     <= cnt_nxt;
      in_rdy_r  <= in_rdy_nxt;
      out_vld_r <= out_vld_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_r] <= wr.data;
    end
  end

  // ready is still low from reset on the first edge after release
  fifo_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !$past(sys_rst) |-> in_rdy_r == (cnt_r != (AW+1)'(DEPTH))) else $error("fifo ready does not match level");
endmodule

/* File: hw/msl_supervisor.sv */
`timescale 1ns/1ps
// Function
// R1: modem ports start at 1200 baud until the rate is changed.
// R2: measure line rate from a received carriage return, then switch to it.
// R3: watch data-set-ready and carrier-detect continuously during a session.
// R4: any drop of data-terminal-ready logs the session off.
// R5: clear-to-send and ring-indicator have no effect at all.
// R6: data-set-ready lost: drop DTR 5 seconds, keep RTS up.
// R7: carrier lost: drop DTR 5 seconds, keep RTS up.
// R8: carrier lost after 30 s inactive or 50 consecutive toggles.
// R9: port 7 is always a modem port.
// R10: console only on modem port 7 of the slot 1 board.
// R11: single-ended direct port carries data only, no handshake.
// R12: balanced direct port carries data as A/B pairs, no handshake.
// R13: logoff command drops DTR 5 seconds, keeps RTS, then reasserts DTR.
// R14: modem raises DSR on DTR and DCD once dialled, before a session.
module msl_supervisor import msl_pkg::*; #(
  parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
  parameter int unsigned LOSS_CYCLES  = LOSS_CYC,
  parameter int unsigned QUIET_CYCLES = QUIET_CYC,
  parameter int unsigned PORT_NUM     = MODEM_PORT,
  parameter int unsigned SLOT_NUM     = CONSOLE_SLOT,
  parameter int          DATA_W       = 8,
  parameter int          FIFO_DEPTH   = 16,
  parameter int          DIV_W        = 20
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // straps, caught during reset
  input  wire logic              modem_strap,
  input  wire logic              balanced_strap,
  // modem control lines
  input  wire logic              dsr,
  input  wire logic              dcd,
  input  wire logic              cts,
  input  wire logic              ri,
  output logic                   dtr_r,
  output logic                   rts_r,
  // serial data pins
  input  wire logic              td,
  input  wire logic              td_a,
  input  wire logic              td_b,
  output logic                   rd_r,
  output logic                   rd_a_r,
  output logic                   rd_b_r,
  // framer side
  input  wire logic              tx_bit,
  output logic                   rx_bit_r,
  output logic [DIV_W-1:0]       baud_div_r,
  // outbound characters
  input  wire logic              host_valid,
  input  wire logic [DATA_W-1:0] host_data,
  output logic                   host_ready,
  output logic                   tx_valid_r,
  output logic [DATA_W-1:0]      tx_data_r,
  input  wire logic              tx_ready,
  // session control and status
  input  wire logic              logoff_command,
  output logic                   session_r,
  output logic                   logoff_r,
  output logic [1:0]             cause_r,
  output logic                   remote_operator_interface_r
);
  // ----------------------------------------------------------------
  // port configuration
  // ----------------------------------------------------------------
  logic modem_r, balanced_r;
  logic line_bit;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      modem_r    <= modem_strap | (PORT_NUM == MODEM_PORT); // see R9
      balanced_r <= balanced_strap & ~(PORT_NUM == MODEM_PORT);
      remote_operator_interface_r <= (PORT_NUM == MODEM_PORT) && (SLOT_NUM == CONSOLE_SLOT); // see R10
    end
  end

  // balanced pairs are resolved to one level; idle pair reads as mark
  assign line_bit = balanced_r ? (td_a | ~td_b) : td; // see R12

  always_ff @(posedge ref_clk) begin
    rx_bit_r <= sys_rst ? 1'b1 : line_bit;
    rd_r     <= sys_rst ? 1'b1 : tx_bit;
    rd_a_r   <= sys_rst ? 1'b1 : tx_bit; // see R12
    rd_b_r   <= sys_rst ? 1'b0 : ~tx_bit;
  end

  // ----------------------------------------------------------------
  // session supervisor
  // ----------------------------------------------------------------
  msl_sup_t    sup_r, sup_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic [31:0] quiet_r, quiet_nxt;
  logic [5:0]  tog_r, tog_nxt;
  logic        dcd_q_r, dcd_edge, carrier_lost;
  logic        dtr_nxt, rts_nxt, logoff_nxt;
  logic [1:0]  cause_nxt;

  // cts and ri are deliberately never read by the supervisor logic below, only by the ctl_ignored_a check (see R5)
  assign dcd_edge     = dcd ^ dcd_q_r;
  assign carrier_lost = (!dcd && timer_r >= LOSS_CYCLES - 1) ||
                        (dcd_edge && tog_r == TOGGLE_LIMIT - 6'h01); // see R8

  always_comb begin
    sup_nxt    = sup_r;
    timer_nxt  = timer_r;
    quiet_nxt  = quiet_r;
    tog_nxt    = tog_r;
    cause_nxt  = cause_r;
    logoff_nxt = 1'b0;
    dtr_nxt    = modem_r;
    rts_nxt    = modem_r;
    if (!modem_r) begin
      // direct ports have no handshake: always in session
      sup_nxt = SUP_ACTIVE; // see R11
      dtr_nxt = 1'b0;
      rts_nxt = 1'b0;
    end else begin
      case (sup_r)
        SUP_WAIT: begin
          timer_nxt = '0;
          tog_nxt   = '0;
          quiet_nxt = '0;
          if (dsr && dcd) begin
            sup_nxt = SUP_ACTIVE; // see R14
          end
        end
        SUP_ACTIVE: begin
          // a toggle burst only counts while edges keep coming
          timer_nxt = dcd ? '0 : timer_r + 32'h1;
          quiet_nxt = dcd_edge ? '0 : quiet_r + 32'h1;
          if (dcd_edge) begin
            tog_nxt = tog_r + 6'h01;
          end else if (quiet_r >= QUIET_CYCLES - 1) begin
            tog_nxt = '0;
          end
          if (!dsr) begin
            cause_nxt = CAUSE_DSR; // see R3, R6
          end else if (carrier_lost) begin
            cause_nxt = CAUSE_CARRIER; // see R3, R7
          end else if (logoff_command) begin
            cause_nxt = CAUSE_LOGOFF; // see R13
          end
          if (!dsr || carrier_lost || logoff_command) begin
            sup_nxt    = SUP_HOLD;
            timer_nxt  = '0;
            dtr_nxt    = 1'b0;
            logoff_nxt = 1'b1; // see R4
          end
        end
        SUP_HOLD: begin
          dtr_nxt   = 1'b0; // see R6, R7, R13
          timer_nxt = timer_r + 32'h1;
          if (timer_r >= HOLD_CYCLES - 1) begin
            sup_nxt   = SUP_WAIT;
            dtr_nxt   = 1'b1;
            timer_nxt = '0;
          end
        end
        default: sup_nxt = SUP_WAIT;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sup_r     <= SUP_WAIT;
      timer_r   <= '0;
      quiet_r   <= '0;
      tog_r     <= '0;
      dcd_q_r   <= 1'b0;
      dtr_r     <= 1'b0;
      rts_r     <= 1'b0;
      logoff_r  <= 1'b0;
      cause_r   <= CAUSE_NONE;
      session_r <= 1'b0;
    end else begin
      sup_r     <= sup_nxt;
      timer_r   <= timer_nxt;
      quiet_r   <= quiet_nxt;
      tog_r     <= tog_nxt;
      dcd_q_r   <= dcd;
      dtr_r     <= dtr_nxt;
      rts_r     <= rts_nxt;
      logoff_r  <= logoff_nxt;
      cause_r   <= cause_nxt;
      session_r <= sup_nxt == SUP_ACTIVE;
    end
  end

  // ----------------------------------------------------------------
  // speed sensing on carriage return
  // ----------------------------------------------------------------
  msl_sns_t         sns_r, sns_nxt;
  logic [DIV_W-1:0] cnt_r, cnt_nxt, per_r, per_nxt, div_nxt;
  logic [3:0]       idx_r, idx_nxt;
  logic [8:0]       shr_r, shr_nxt;

  // start bit of a carriage return is a lone low cell, so its width is one bit time
  always_comb begin
    sns_nxt = sns_r;
    cnt_nxt = cnt_r;
    per_nxt = per_r;
    idx_nxt = idx_r;
    shr_nxt = shr_r;
    div_nxt = baud_div_r;
    if (modem_r && sup_r == SUP_HOLD) begin
      // every new session starts over at the default rate
      sns_nxt = SNS_ARM;
      div_nxt = DIV_W'(DEFAULT_DIV); // see R1
    end else begin
      case (sns_r)
        SNS_ARM: begin
          cnt_nxt = '0;
          idx_nxt = '0;
          if (!line_bit) begin
            sns_nxt = SNS_MEAS;
          end
        end
        SNS_MEAS: begin
          if (!line_bit) begin
            cnt_nxt = cnt_r + 1'b1;
            if (&cnt_r) begin
              sns_nxt = SNS_ARM;
            end
          end else begin
            per_nxt = cnt_r + 1'b1;
            cnt_nxt = cnt_r >> 1;
            sns_nxt = SNS_SAMP;
          end
        end
        SNS_SAMP: begin
          if (cnt_r == '0) begin
            shr_nxt = {line_bit, shr_r[8:1]};
            idx_nxt = idx_r + 4'h1;
            cnt_nxt = per_r - 1'b1;
            if (idx_r == CHAR_BITS - 4'h1) begin
              if (shr_nxt[7:0] == CR_CHAR && shr_nxt[8]) begin
                div_nxt = per_r; // see R2
                sns_nxt = SNS_LOCK;
              end else begin
                sns_nxt = SNS_ARM;
              end
            end
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        default: sns_nxt = sns_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sns_r      <= SNS_ARM;
      cnt_r      <= '0;
      per_r      <= '0;
      idx_r      <= '0;
      shr_r      <= '0;
      baud_div_r <= DIV_W'(DEFAULT_DIV); // see R1
    end else begin
      sns_r      <= sns_nxt;
      cnt_r      <= cnt_nxt;
      per_r      <= per_nxt;
      idx_r      <= idx_nxt;
      shr_r      <= shr_nxt;
      baud_div_r <= div_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outbound character path
  // ----------------------------------------------------------------
  msl_stream_if #(.DATA_W(DATA_W)) fill_if ();
  msl_stream_if #(.DATA_W(DATA_W)) drain_if ();
  logic              take, tx_valid_nxt;
  logic [DATA_W-1:0] tx_data_nxt;

  assign fill_if.valid = host_valid;
  assign fill_if.data  = host_data;
  assign host_ready    = fill_if.ready;

  // nothing leaves while no session is open, so the fifo fills and stalls the host
  assign take           = drain_if.valid && session_r && (!tx_valid_r || tx_ready);
  assign drain_if.ready = take;

  msl_fifo #(.DATA_W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .wr      (fill_if),
    .rd      (drain_if)
  );

  always_comb begin
    tx_valid_nxt = tx_valid_r && !tx_ready;
    tx_data_nxt  = tx_data_r;
    if (take) begin
      tx_valid_nxt = 1'b1;
      tx_data_nxt  = drain_if.data;
    end
  end

  always_ff @(posedge ref_clk) begin
    tx_valid_r <= sys_rst ? 1'b0 : tx_valid_nxt;
    tx_data_r  <= sys_rst ? '0 : tx_data_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  rate_default_a: assert property ($fell(sys_rst) |-> baud_div_r == DIV_W'(DEFAULT_DIV)) // see R1
    else $error("rate not default after reset");
  rate_change_a: assert property ($changed(baud_div_r) |-> $past(sns_r) == SNS_SAMP || $past(sup_r) == SUP_HOLD) // see R2
    else $error("rate changed without sensing");
  dsr_watch_a: assert property (modem_r && sup_r == SUP_ACTIVE && !dsr |=> sup_r == SUP_HOLD && cause_r == CAUSE_DSR) // see R3
    else $error("dsr loss missed");
  drop_logoff_a: assert property (modem_r && $fell(dtr_r) |-> logoff_r) // see R4
    else $error("dtr dropped without logoff");
  ctl_ignored_a: assert property ($changed(cts) || $changed(ri) |=> $stable(dtr_r) || $past(sup_r) != SUP_ACTIVE || !$past(dsr) || $past(carrier_lost) || $past(logoff_command)) // see R5
    else $error("cts or ri affected session");
  hold_lines_a: assert property (modem_r && sup_r == SUP_HOLD |-> !dtr_r && rts_r) // see R6
    else $error("hold lines wrong");
  hold_length_a: assert property (sup_r == SUP_HOLD && timer_r < HOLD_CYCLES - 1 |=> sup_r == SUP_HOLD && !dtr_r) // see R7
    else $error("hold ended early");
  toggle_loss_a: assert property (modem_r && sup_r == SUP_ACTIVE && dsr && dcd_edge && tog_r == TOGGLE_LIMIT - 6'h01 |=> sup_r == SUP_HOLD && cause_r == CAUSE_CARRIER) // see R8
    else $error("noisy carrier missed");
  console_port_a: assert property (remote_operator_interface_r |-> modem_r) // see R10
    else $error("console on non modem port");
  direct_quiet_a: assert property (!modem_r && !$past(sys_rst) |-> !dtr_r && !rts_r && session_r) // see R11
    else $error("direct port drives handshake");
  logoff_cmd_a: assert property (modem_r && sup_r == SUP_ACTIVE && dsr && !carrier_lost && logoff_command |=> logoff_r ##1 !logoff_r && !dtr_r) // see R13
    else $error("logoff command ignored");

  hold_seen_c: cover property (sup_r == SUP_ACTIVE ##1 sup_r == SUP_HOLD);
  rate_lock_c: cover property (sns_r == SNS_SAMP ##1 sns_r == SNS_LOCK);
  fifo_full_c: cover property (!host_ready && host_valid);
endmodule

/* File: verification/msl_modem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// modem on the far side of port 7
// ----------------------------------------------------------------
module msl_modem_model (
  // clock
  input  wire logic ref_clk,
  // bench commands
  input  wire logic power_on,
  input  wire logic dialled,
  // line from the port
  input  wire logic dtr,
  // lines toward the port
  output logic      dsr,
  output logic      dcd
);
  // answers dtr one cycle late, and carrier only once dsr is up
  always @(posedge ref_clk) begin
    dsr <= power_on & dtr;
    dcd <= dialled & power_on & dsr;
  end
endmodule

/* File: verification/modem_line_supervisor_tb_top.sv */
`timescale 1ns/1ps
module modem_line_supervisor_tb_top;
  import msl_pkg::*;
  localparam int unsigned HOLD = 50;
  localparam int unsigned LOSS = 200;
  localparam int unsigned QUIET = 40;
  localparam int unsigned DEPTH = 16;

  logic ref_clk, sys_rst, dsr, dcd, cts, ri, dtr_r, rts_r, td, td_a, td_b;
  logic rd_r, rd_a_r, rd_b_r, tx_bit, rx_bit_r, host_valid, host_ready;
  logic tx_valid_r, tx_ready, logoff_command, session_r, logoff_r, console_r;
  logic d_dtr, d_rts, d_rd_a, d_rd_b, d_sess, d_console;
  logic [19:0] d_div;
  logic power_on, dialled;
  logic [19:0] baud_div_r;
  logic [7:0] host_data, tx_data_r;
  logic [1:0] cause_r;
  int n_errors, checks_done, cyc;

  msl_supervisor #(.HOLD_CYCLES(HOLD), .LOSS_CYCLES(LOSS), .QUIET_CYCLES(QUIET)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .modem_strap(1'b1), .balanced_strap(1'b0),
    .dsr(dsr), .dcd(dcd), .cts(cts), .ri(ri), .dtr_r(dtr_r), .rts_r(rts_r),
    .td(td), .td_a(td_a), .td_b(td_b), .rd_r(rd_r), .rd_a_r(rd_a_r), .rd_b_r(rd_b_r),
    .tx_bit(tx_bit), .rx_bit_r(rx_bit_r), .baud_div_r(baud_div_r),
    .host_valid(host_valid), .host_data(host_data), .host_ready(host_ready),
    .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r), .tx_ready(tx_ready),
    .logoff_command(logoff_command), .session_r(session_r), .logoff_r(logoff_r),
    .cause_r(cause_r), .remote_operator_interface_r(console_r));

  // balanced direct port on another board: no handshake, no console
  msl_supervisor #(.PORT_NUM(3), .SLOT_NUM(2)) u_dut_direct (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .modem_strap(1'b0), .balanced_strap(1'b1),
    .dsr(1'b0), .dcd(1'b0), .cts(cts), .ri(ri), .dtr_r(d_dtr), .rts_r(d_rts),
    .td(1'b1), .td_a(td_a), .td_b(td_b), .rd_r(), .rd_a_r(d_rd_a), .rd_b_r(d_rd_b),
    .tx_bit(tx_bit), .rx_bit_r(), .baud_div_r(d_div),
    .host_valid(1'b0), .host_data(8'h00), .host_ready(),
    .tx_valid_r(), .tx_data_r(), .tx_ready(1'b0),
    .logoff_command(logoff_command), .session_r(d_sess), .logoff_r(),
    .cause_r(), .remote_operator_interface_r(d_console));

  msl_modem_model u_modem (
    .ref_clk(ref_clk), .power_on(power_on), .dialled(dialled), .dtr(dtr_r), .dsr(dsr), .dcd(dcd));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // the whole run needs under two thousand cycles; a hang is stopped at cycle 20000 and counted as an error
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  task automatic wait_sess;
    int i;
    i = 0;
    while (session_r !== 1'b1 && i < 20) begin
      @(negedge ref_clk);
      i++;
    end
    chk(session_r, 1);
  endtask

  // logoff pulse, cause, dtr low for the whole hold with rts untouched
  task automatic hold_check(input logic [1:0] c);
    int i;
    int lo;
    i = 0;
    while (logoff_r !== 1'b1 && i < 300) begin
      @(negedge ref_clk);
      i++;
    end
    chk(cause_r, c);
    chk(session_r, 0);
    chk(dtr_r, 0);
    lo = 0;
    while (dtr_r !== 1'b1 && lo < 200) begin
      lo++;
      chk(rts_r, 1);
      @(negedge ref_clk);
      if (lo == 1)
        chk(logoff_r, 0);
    end
    chk(lo, HOLD);
    chk(baud_div_r, DEFAULT_DIV);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic after_reset;
    chk({dtr_r, rts_r, session_r, console_r, host_ready}, 5'h1b);
    chk({d_dtr, d_rts, d_sess, d_console}, 4'h2);
    chk(baud_div_r, DEFAULT_DIV);
  endtask

  // carriage return at a foreign rate, start bit is the first low run
  task automatic sense_speed(input int n);
    logic [9:0] frame;
    frame = {1'b1, CR_CHAR, 1'b0};
    for (int b = 0; b < 10; b++) begin
      td = frame[b];
      td_a = frame[b];
      td_b = ~frame[b];
      repeat (n) @(negedge ref_clk);
    end
    repeat (5) @(negedge ref_clk);
    chk(baud_div_r, n);
    chk(d_div, n);
  endtask

  task automatic ignore_cts_ri;
    for (int i = 0; i < 8; i++) begin
      cts = i[0];
      ri = i[1];
      @(negedge ref_clk);
    end
    chk({session_r, dtr_r, logoff_r}, 3'h6);
  endtask

  // fill with the framer stalled, then drain and check order
  task automatic data_path;
    int n;
    int k;
    n = 0;
    tx_ready = 1'b0;
    repeat (30) begin
      if (host_ready === 1'b1) begin
        host_valid = 1'b1;
        host_data = 8'(n);
        n++;
      end else
        host_valid = 1'b0;
      @(negedge ref_clk);
    end
    host_valid = 1'b0;
    chk(n, DEPTH + 1);
    chk(host_ready, 0);
    tx_ready = 1'b1;
    k = 0;
    repeat (40) begin
      if (tx_valid_r === 1'b1) begin
        chk(tx_data_r, k);
        k++;
      end
      @(negedge ref_clk);
    end
    tx_ready = 1'b0;
    chk(k, DEPTH + 1);
    tx_bit = 1'b0;
    @(negedge ref_clk);
    chk({rd_r, rd_a_r, rd_b_r}, 3'b001);
    chk({d_rd_a, d_rd_b}, 2'b01);
    tx_bit = 1'b1;
    @(negedge ref_clk);
    chk({rd_r, rd_a_r, rd_b_r}, 3'b110);
    chk({d_rd_a, d_rd_b}, 2'b10);
  endtask

  task automatic logoff_cmd;
    logoff_command = 1'b1;
    @(negedge ref_clk);
    logoff_command = 1'b0;
    hold_check(CAUSE_LOGOFF);
  endtask

  task automatic dsr_loss;
    power_on = 1'b0;
    @(negedge ref_clk);
    power_on = 1'b1;
    hold_check(CAUSE_DSR);
  endtask

  task automatic carrier_quiet;
    dialled = 1'b0;
    repeat (LOSS - 20) @(negedge ref_clk);
    chk(session_r, 1);
    dialled = 1'b1;
    @(negedge ref_clk);
    dialled = 1'b0;
    hold_check(CAUSE_CARRIER);
    dialled = 1'b1;
  endtask

  // 49 fast toggles keep the session, the 50th ends it
  task automatic carrier_noise;
    for (int e = 0; e < 49; e++) begin
      dialled = ~dialled;
      repeat (2) @(negedge ref_clk);
    end
    repeat (2) @(negedge ref_clk);
    chk(session_r, 1);
    dialled = 1'b1;
    hold_check(CAUSE_CARRIER);
    chk({d_dtr, d_rts, d_sess}, 3'h1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    {cts, ri, logoff_command, host_valid, tx_ready, power_on, dialled} = 7'h00;
    {td, td_a, td_b, tx_bit} = 4'hf;
    host_data = 8'h00;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    after_reset();
    sense_speed(24);
    power_on = 1'b1;
    dialled = 1'b1;
    wait_sess();
    ignore_cts_ri();
    data_path();
    logoff_cmd();
    wait_sess();
    dsr_loss();
    wait_sess();
    carrier_quiet();
    wait_sess();
    carrier_noise();
    print_verdict();
  end
endmodule
